/* File: common/cirq_link_if.sv */
// Signals between the bit-clock monitor and the interrupt core
interface cirq_link_if;
  import cirq_pkg::*;
  logic [EVT_N-1:0] evt;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic [EVT_N-1:0] evt_tgl;
  logic [LVL_N-1:0] fault_lvl;
  modport link (input evt, input tx_cnt, input rx_cnt, output evt_tgl, output fault_lvl);
  modport core (output evt, output tx_cnt, output rx_cnt, input evt_tgl, input fault_lvl);
endinterface

/* File: common/cirq_pkg.sv */
// Constants, encodings and register map of the interrupt logic
package cirq_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_INT_EN = 7'h2B;
  localparam logic [6:0] ADDR_INT_FLAGS = 7'h2C;
  localparam logic [6:0] ADDR_FAULT_STATUS = 7'h2D;
  localparam logic [6:0] ADDR_CTRL_STATUS = 7'h30;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Enable / flag bit positions
  // ----------------------------------------------------------------
  localparam int BIT_MSG_FAULT = 7;
  localparam int BIT_WAKE = 6;
  localparam int BIT_FAULT_STATE = 5;
  localparam int BIT_TX2 = 4;
  localparam int BIT_TX1 = 3;
  localparam int BIT_TX0 = 2;
  localparam int BIT_RX1 = 1;
  localparam int BIT_RX0 = 0;
  // ----------------------------------------------------------------
  // Priority codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_FAULT = 3'h1;
  localparam logic [2:0] CODE_WAKE = 3'h2;
  localparam logic [2:0] CODE_TX0 = 3'h3;
  localparam logic [2:0] CODE_TX1 = 3'h4;
  localparam logic [2:0] CODE_TX2 = 3'h5;
  localparam logic [2:0] CODE_RX0 = 3'h6;
  localparam logic [2:0] CODE_RX1 = 3'h7;
  // ----------------------------------------------------------------
  // Status fields, fault levels, link events
  // ----------------------------------------------------------------
  localparam int STAT_MODE_LSB = 5;
  localparam int STAT_CODE_LSB = 1;
  localparam logic [2:0] MODE_ENC_NORMAL = 3'h0;
  localparam logic [2:0] MODE_ENC_SLEEP = 3'h1;
  localparam logic [2:0] MODE_ENC_LISTEN = 3'h3;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] WARN_LIMIT = 9'h060;
  localparam logic [CNT_W-1:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [CNT_W-1:0] BUSOFF_LIMIT = 9'h0FF;
  localparam int LVL_N = 5;
  localparam int LVL_RX_WARN = 0;
  localparam int LVL_TX_WARN = 1;
  localparam int LVL_RX_PASSIVE = 2;
  localparam int LVL_TX_PASSIVE = 3;
  localparam int LVL_BUS_OFF = 4;
  localparam int EVT_N = 8;
  localparam int EV_MSG_FAULT = 5;
  localparam int EV_OVR0 = 6;
  localparam int EV_OVR1 = 7;
  typedef enum {MODE_NORMAL, MODE_SLEEP, MODE_LISTEN} cirq_mode_t;
endpackage

/* File: logic/cirq_link_mon.sv */
// Bit-clock side: event toggles and fault-state levels from error counts
module cirq_link_mon
  import cirq_pkg::*;
(
  // Clock and reset
  input wire logic can_clk,
  input wire logic rst_n,
  // Link side
  cirq_link_if.link lk
);
  logic [EVT_N-1:0] tgl_r, tgl_nxt;
  logic [LVL_N-1:0] lvl_r, lvl_nxt;

  always_comb
  begin
    // Each event pulse flips its toggle so the slow side cannot miss it
    tgl_nxt = tgl_r ^ lk.evt;
    // (R13) warning limits
    lvl_nxt[LVL_RX_WARN] = lk.rx_cnt >= WARN_LIMIT;
    lvl_nxt[LVL_TX_WARN] = lk.tx_cnt >= WARN_LIMIT;
    // (R14) passive limits
    lvl_nxt[LVL_RX_PASSIVE] = lk.rx_cnt > PASSIVE_LIMIT;
    lvl_nxt[LVL_TX_PASSIVE] = lk.tx_cnt > PASSIVE_LIMIT;
    // (R15) bus-off limit
    lvl_nxt[LVL_BUS_OFF] = lk.tx_cnt > BUSOFF_LIMIT;
  end

  always_ff @(posedge can_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_r <= '0;
      lvl_r <= '0;
    end
    else
    begin
      tgl_r <= tgl_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign lk.evt_tgl = tgl_r;
  assign lk.fault_lvl = lvl_r;

  chk_warn_level: assert property (@(posedge can_clk) disable iff (!rst_n) // R13
    lk.tx_cnt == WARN_LIMIT |=> lvl_r[LVL_TX_WARN]) else $error("tx warning not raised at limit");
  chk_busoff_level: assert property (@(posedge can_clk) disable iff (!rst_n) // R15
    lvl_r[LVL_BUS_OFF] |-> $past(lk.tx_cnt) > BUSOFF_LIMIT) else $error("bus-off without count above limit");
  chk_passive_level: assert property (@(posedge can_clk) disable iff (!rst_n) // R14
    lk.rx_cnt == PASSIVE_LIMIT |=> !lvl_r[LVL_RX_PASSIVE]) else $error("rx passive at count 127");
endmodule // cirq_link_mon

/* File: logic/cirq_top.sv */
// Interrupt flags, enables, priority code and interrupt pin of the controller
//
// Function
// (R1) Code field shows highest-priority pending source; lower code wins.
// (R2) After a clear, the code moves to the next pending source or none.
// (R3) Codes: 0 none, 1 error, 2 wake, 3-5 transmit 0-2, 6-7 receive 0-1.
// (R4) Only enabled sources enter the code field.
// (R5) Pin stays asserted while any enabled flag is set.
// (R6) Transmit buffer empty sets its flag; clearing removes the interrupt.
// (R7) Receive buffer flag set once end of frame was received into it.
// (R8) Any message error sets bit 7 and interrupts when enabled.
// (R9) In sleep with wake enabled, bus activity sets bit 6 and leaves sleep.
// (R10) Leaving sleep on bus activity enters listen-only mode.
// (R11) Overflow or error-state change sets bit 5, interrupting when enabled.
// (R12) Overflow on an occupied receive buffer sets its bit; host clears it.
// (R13) Warnings when receive or transmit error count reaches 96.
// (R14) Error-passive flagged per direction when count exceeds 127.
// (R15) Bus-off flagged when transmit error count exceeds 255.
// (R16) A clear has no effect while its setting condition persists.
// (R17) Enable and flag registers share one layout, all read/write, reset 0.
// (R18) Host clears flags itself; the device never clears them.
// (R19) Interrupt pin is active low.
// (R20) Host setting a flag interrupts like a hardware event when enabled.
// (R21) Host should clear flags by masked bit-modify writes.
// (R22) Code field is read-only and follows flags and enables at once.
module cirq_top
  import cirq_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic can_clk,
  // Register port from the serial block
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_wr_mask,
  input wire logic [6:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  // Protocol engine events, bit-clock domain
  input wire logic [2:0] tx_empty_evt,
  input wire logic [1:0] rx_full_evt,
  input wire logic msg_fault_evt,
  input wire logic [1:0] rx_overrun_evt,
  input wire logic [CNT_W-1:0] tx_fault_count,
  input wire logic [CNT_W-1:0] rx_fault_count,
  // Bus receive pin
  input wire logic rxcan,
  // Mode requests and state
  input wire logic sleep_req,
  input wire logic normal_req,
  output logic in_sleep,
  output logic listen_only,
  // Interrupt outputs
  output logic int_n,
  output logic [2:0] irq_priority_code
);
  // ----------------------------------------------------------------
  // Link monitor
  // ----------------------------------------------------------------
  cirq_link_if lk ();

  assign lk.evt = {rx_overrun_evt, msg_fault_evt, rx_full_evt, tx_empty_evt};
  assign lk.tx_cnt = tx_fault_count;
  assign lk.rx_cnt = rx_fault_count;

  cirq_link_mon u_link (
    .can_clk (can_clk),
    .rst_n (rst_n),
    .lk (lk)
  );

  // ----------------------------------------------------------------
  // Crossings into clk
  // ----------------------------------------------------------------
  logic [EVT_N-1:0] tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic [LVL_N-1:0] lvl_s1_r, lvl_s2_r, lvl_d_r;
  logic [LVL_N-1:0] lvl_ok_r, lvl_ok_nxt;
  logic rx_s1_r, rx_s2_r;
  logic [EVT_N-1:0] evp;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_s1_r <= '0;
      tgl_s2_r <= '0;
      tgl_s3_r <= '0;
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
      lvl_d_r <= '0;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      tgl_s1_r <= lk.evt_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      lvl_s1_r <= lk.fault_lvl;
      lvl_s2_r <= lvl_s1_r;
      lvl_d_r <= lvl_s2_r;
      rx_s1_r <= rxcan;
      rx_s2_r <= rx_s1_r;
    end
  end

  generate
    for (genvar i = 0; i < EVT_N; i++)
    begin : g_evt
      assign evp[i] = tgl_s2_r[i] ^ tgl_s3_r[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  // (R1) (R2) (R3) fixed order, lower code wins
  function automatic logic [2:0] prio_code(input logic [7:0] pend);
    logic [2:0] c;
    c = CODE_NONE;
    if (pend[BIT_FAULT_STATE])
      c = CODE_FAULT;
    else if (pend[BIT_WAKE])
      c = CODE_WAKE;
    else if (pend[BIT_TX0])
      c = CODE_TX0;
    else if (pend[BIT_TX1])
      c = CODE_TX1;
    else if (pend[BIT_TX2])
      c = CODE_TX2;
    else if (pend[BIT_RX0])
      c = CODE_RX0;
    else if (pend[BIT_RX1])
      c = CODE_RX1;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Flags, enables, overflow bits, mode
  // ----------------------------------------------------------------
  logic [7:0] en_r, en_nxt;
  logic [7:0] flag_r, flag_nxt;
  logic [1:0] ovr_r, ovr_nxt;
  cirq_mode_t mode_r, mode_nxt;
  logic [2:0] code_r, code_nxt;
  logic int_n_r, int_n_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [7:0] hw_set, hold, wr_val, fs_val, stat_val;
  logic wake_hit;

  always_comb
  begin
    // Bus activity: a dominant (low) level on the receive pin
    wake_hit = (mode_r == MODE_SLEEP) && en_r[BIT_WAKE] && !rx_s2_r;
    hw_set = '0;
    // (R6) transmit buffers emptied
    hw_set[BIT_TX0] = evp[0];
    hw_set[BIT_TX1] = evp[1];
    hw_set[BIT_TX2] = evp[2];
    // (R7) receive buffers loaded after end of frame
    hw_set[BIT_RX0] = evp[3];
    hw_set[BIT_RX1] = evp[4];
    // (R8) message error
    hw_set[BIT_MSG_FAULT] = evp[EV_MSG_FAULT];
    // Levels pass only once two samples agree, so bits that cross a cycle apart never mix
    lvl_ok_nxt = (lvl_s2_r == lvl_d_r) ? lvl_d_r : lvl_ok_r;
    // (R11) overflow or fault-state change
    hw_set[BIT_FAULT_STATE] = (lvl_ok_nxt != lvl_ok_r) || evp[EV_OVR0] || evp[EV_OVR1];
    // (R9) bus activity wake
    hw_set[BIT_WAKE] = wake_hit;
    // (R16) conditions still present block a host clear
    hold = hw_set;
    hold[BIT_FAULT_STATE] = hw_set[BIT_FAULT_STATE] || (|ovr_r);

    en_nxt = en_r;
    wr_val = flag_r;
    ovr_nxt = ovr_r;
    if (reg_wr_en && reg_wr_addr == ADDR_INT_EN)
      // (R17) enable register is plain read/write, bit-modify capable
      en_nxt = (en_r & ~reg_wr_mask) | (reg_wr_data & reg_wr_mask);
    else if (reg_wr_en && reg_wr_addr == ADDR_INT_FLAGS)
      // (R20) host may set flags as well as clear them
      wr_val = (flag_r & ~reg_wr_mask) | (reg_wr_data & reg_wr_mask);
    else if (reg_wr_en && reg_wr_addr == ADDR_FAULT_STATUS)
      ovr_nxt = (ovr_r & ~reg_wr_mask[7:6]) | (reg_wr_data[7:6] & reg_wr_mask[7:6]);
    // (R12) overflow bits set by hardware, set wins over host clear
    ovr_nxt = ovr_nxt | {evp[EV_OVR1], evp[EV_OVR0]};
    // (R18) only the host write path can lower a flag
    flag_nxt = wr_val | (flag_r & hold) | hw_set;

    mode_nxt = mode_r;
    // (R10) wake-up leads to listen-only, also on a host-set wake flag
    if (mode_r == MODE_SLEEP && en_r[BIT_WAKE] && flag_nxt[BIT_WAKE])
      mode_nxt = MODE_LISTEN;
    else if (sleep_req)
      mode_nxt = MODE_SLEEP;
    else if (normal_req)
      mode_nxt = MODE_NORMAL;

    // (R4) only enabled flags reach the code and the pin
    // (R22) code follows the new flag and enable values in the same edge
    code_nxt = prio_code(flag_nxt & en_nxt);
    // (R19) active low pin, (R5) low while anything enabled is pending
    int_n_nxt = ~|(flag_nxt & en_nxt);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_r <= REG_RESET;
      flag_r <= REG_RESET;
      ovr_r <= '0;
      lvl_ok_r <= '0;
      mode_r <= MODE_NORMAL;
      code_r <= CODE_NONE;
      int_n_r <= 1'b1;
    end
    else
    begin
      en_r <= en_nxt;
      flag_r <= flag_nxt;
      ovr_r <= ovr_nxt;
      lvl_ok_r <= lvl_ok_nxt;
      mode_r <= mode_nxt;
      code_r <= code_nxt;
      int_n_r <= int_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    // Ewarn is the union of the two warnings
    fs_val = {ovr_r, lvl_ok_r, lvl_ok_r[LVL_RX_WARN] | lvl_ok_r[LVL_TX_WARN]};
    stat_val = REG_RESET;
    stat_val[STAT_CODE_LSB +: 3] = code_r;
    if (mode_r == MODE_SLEEP)
      stat_val[STAT_MODE_LSB +: 3] = MODE_ENC_SLEEP;
    else if (mode_r == MODE_LISTEN)
      stat_val[STAT_MODE_LSB +: 3] = MODE_ENC_LISTEN;
    else
      stat_val[STAT_MODE_LSB +: 3] = MODE_ENC_NORMAL;
    if (reg_rd_addr == ADDR_INT_EN)
      rd_nxt = en_r;
    else if (reg_rd_addr == ADDR_INT_FLAGS)
      rd_nxt = flag_r;
    else if (reg_rd_addr == ADDR_FAULT_STATUS)
      rd_nxt = fs_val;
    else if (reg_rd_addr == ADDR_CTRL_STATUS)
      rd_nxt = stat_val;
    else
      rd_nxt = REG_RESET;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_r <= REG_RESET;
    else
      rd_r <= rd_nxt;
  end

  // Mode flags are registered together with the mode itself
  logic sleep_o_r, listen_o_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_o_r <= 1'b0;
      listen_o_r <= 1'b0;
    end
    else
    begin
      sleep_o_r <= mode_nxt == MODE_SLEEP;
      listen_o_r <= mode_nxt == MODE_LISTEN;
    end
  end

  assign reg_rd_data = rd_r;
  assign in_sleep = sleep_o_r;
  assign listen_only = listen_o_r;
  assign int_n = int_n_r;
  assign irq_priority_code = code_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_sleep_activity;
    mode_r == MODE_SLEEP && en_r[BIT_WAKE] && !rx_s2_r;
  endsequence

  sequence s_woken;
    mode_r == MODE_LISTEN && flag_r[BIT_WAKE] && !int_n_r;
  endsequence

  chk_code_none: assert property ( // R3
    ((flag_r & en_r & 8'h7F) == 8'h00) |-> code_r == CODE_NONE) else $error("code not none when idle");
  chk_code_fault: assert property ( // R1
    flag_r[BIT_FAULT_STATE] && en_r[BIT_FAULT_STATE] |-> code_r == CODE_FAULT) else $error("error source not first");
  chk_code_next: assert property ( // R2
    !(flag_r[BIT_FAULT_STATE] && en_r[BIT_FAULT_STATE]) && flag_r[BIT_WAKE] && en_r[BIT_WAKE]
    |-> code_r == CODE_WAKE) else $error("code did not fall to wake");
  chk_masked_hidden: assert property ( // R4
    code_r == CODE_RX1 |-> flag_r[BIT_RX1] && en_r[BIT_RX1]) else $error("disabled source in code");
  chk_pin_pending: assert property ( // R5
    !int_n_r == (|(flag_r & en_r))) else $error("pin does not match pending");
  chk_tx_set: assert property ( // R6
    evp[0] |=> flag_r[BIT_TX0]) else $error("tx0 flag not set");
  chk_wake_leave: assert property ( // R9
    s_sleep_activity |=> s_woken) else $error("no wake-up on bus activity");
  chk_ovr_set: assert property ( // R12
    evp[EV_OVR1] |=> ovr_r[1] ##1 flag_r[BIT_FAULT_STATE]) else $error("overflow not recorded");
  chk_no_auto_clear: assert property ( // R18
    !reg_wr_en |=> (flag_r & $past(flag_r)) == $past(flag_r)) else $error("flag cleared without write");
  chk_fault_change: assert property ( // R11
    lvl_ok_nxt != lvl_ok_r |=> flag_r[BIT_FAULT_STATE]) else $error("state change not flagged");
endmodule // cirq_top

/* File: tb/can_controller_interrupt_logic_test.sv */
// Self-checking bench for interrupt flags, enables, priority code and pin
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module can_controller_interrupt_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cirq_pkg::*;
  logic clk, can_clk, rst_n, reg_wr_en, rxcan, sleep_req, normal_req;
  logic [6:0] reg_wr_addr, reg_rd_addr;
  logic [7:0] reg_wr_data, reg_wr_mask, reg_rd_data;
  logic [2:0] tx_empty_evt, irq_priority_code;
  logic [1:0] rx_full_evt, rx_overrun_evt;
  logic msg_fault_evt, in_sleep, listen_only, int_n;
  logic [CNT_W-1:0] tx_fault_count, rx_fault_count;
  int error_cnt = 0;
  int checks_done = 0;
  cirq_top dut (.clk(clk), .rst_n(rst_n), .can_clk(can_clk), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_mask(reg_wr_mask),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .tx_empty_evt(tx_empty_evt),
    .rx_full_evt(rx_full_evt), .msg_fault_evt(msg_fault_evt), .rx_overrun_evt(rx_overrun_evt),
    .tx_fault_count(tx_fault_count), .rx_fault_count(rx_fault_count), .rxcan(rxcan),
    .sleep_req(sleep_req), .normal_req(normal_req), .in_sleep(in_sleep),
    .listen_only(listen_only), .int_n(int_n), .irq_priority_code(irq_priority_code));
  cirq_eng_model eng (.can_clk(can_clk), .tx_empty_evt(tx_empty_evt), .rx_full_evt(rx_full_evt),
    .msg_fault_evt(msg_fault_evt), .rx_overrun_evt(rx_overrun_evt),
    .tx_fault_count(tx_fault_count), .rx_fault_count(rx_fault_count));
  // ----
  // Clocks, unrelated in phase
  // ----
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    can_clk = 1'b0;
    #7;
    forever #15 can_clk = ~can_clk;
  end
  // ----
  // Register port tasks
  // ----
  task automatic wr(input logic [6:0] a, input logic [7:0] m, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_mask = m;
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd_addr = a;
    @(negedge clk);
    `CHK(reg_rd_data, exp)
  endtask
  // Covers the two-flop crossing plus edge detect with margin
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    `CHK(int_n, 1'b1)
    `CHK(irq_priority_code, CODE_NONE)
    rd_chk(ADDR_INT_EN, REG_RESET);
    rd_chk(ADDR_INT_FLAGS, REG_RESET);
    rd_chk(7'h7F, 8'h00);
  endtask
  task automatic t_prio;
    int order [7] = '{BIT_FAULT_STATE, BIT_WAKE, BIT_TX0, BIT_TX1, BIT_TX2, BIT_RX0, BIT_RX1};
    wr(ADDR_INT_EN, 8'hFF, 8'h7F);
    wr(ADDR_INT_FLAGS, 8'hFF, 8'h7F);
    for (int i = 0; i < 7; i++)
    begin
      `CHK(irq_priority_code, 3'(i + 1))
      `CHK(int_n, 1'b0)
      wr(ADDR_INT_FLAGS, 8'(1 << order[i]), 8'h00);
    end
    `CHK(irq_priority_code, CODE_NONE)
    `CHK(int_n, 1'b1)
  endtask
  task automatic t_mask;
    wr(ADDR_INT_EN, 8'hFF, 8'h00);
    wr(ADDR_INT_FLAGS, 8'hFF, 8'hFF);
    `CHK(int_n, 1'b1)
    `CHK(irq_priority_code, CODE_NONE)
    wr(ADDR_INT_EN, 8'hFF, 8'h80);
    `CHK(int_n, 1'b0)
    `CHK(irq_priority_code, CODE_NONE)
    wr(ADDR_INT_EN, 8'hFF, 8'h18);
    `CHK(irq_priority_code, CODE_TX1)
    wr(ADDR_INT_FLAGS, 8'hFF, 8'h00);
    `CHK(int_n, 1'b1)
  endtask
  task automatic t_events;
    int bitpos [6] = '{BIT_RX0, BIT_RX1, BIT_TX0, BIT_TX1, BIT_TX2, BIT_MSG_FAULT};
    logic [2:0] code [6] = '{CODE_RX0, CODE_RX1, CODE_TX0, CODE_TX1, CODE_TX2, CODE_NONE};
    wr(ADDR_INT_EN, 8'hFF, 8'hFF);
    for (int e = 0; e < 6; e++)
    begin
      eng.pulse(e);
      settle();
      rd_chk(ADDR_INT_FLAGS, 8'(1 << bitpos[e]));
      `CHK(irq_priority_code, code[e])
      `CHK(int_n, 1'b0)
      wr(ADDR_INT_FLAGS, 8'(1 << bitpos[e]), 8'h00);
      `CHK(int_n, 1'b1)
    end
  endtask
  task automatic t_overrun;
    for (int k = 0; k < 2; k++)
    begin
      eng.pulse(EV_OVR0 + k);
      settle();
      rd_chk(ADDR_FAULT_STATUS, 8'(8'h40 << k));
      rd_chk(ADDR_INT_FLAGS, 8'h20);
      wr(ADDR_INT_FLAGS, 8'h20, 8'h00);
      rd_chk(ADDR_INT_FLAGS, 8'h20);
      wr(ADDR_FAULT_STATUS, 8'(8'h40 << k), 8'h00);
      wr(ADDR_INT_FLAGS, 8'h20, 8'h00);
      rd_chk(ADDR_INT_FLAGS, 8'h00);
    end
  endtask
  task automatic t_levels;
    logic [CNT_W-1:0] tc [9] = '{9'h05F, 9'h060, 9'h000, 9'h000, 9'h000, 9'h080, 9'h0FF, 9'h100, 9'h000};
    logic [CNT_W-1:0] rc [9] = '{9'h000, 9'h000, 9'h060, 9'h07F, 9'h080, 9'h000, 9'h000, 9'h000, 9'h000};
    logic [7:0] ex;
    logic [7:0] prev;
    prev = 8'h00;
    for (int i = 0; i < 9; i++)
    begin
      ex = {2'b00, tc[i] > BUSOFF_LIMIT, tc[i] > PASSIVE_LIMIT, rc[i] > PASSIVE_LIMIT,
        tc[i] >= WARN_LIMIT, rc[i] >= WARN_LIMIT, (tc[i] >= WARN_LIMIT) | (rc[i] >= WARN_LIMIT)};
      eng.set_counts(tc[i], rc[i]);
      settle();
      rd_chk(ADDR_FAULT_STATUS, ex);
      rd_chk(ADDR_INT_FLAGS, {2'b00, ex != prev, 5'h00});
      wr(ADDR_INT_FLAGS, 8'h20, 8'h00);
      prev = ex;
    end
  endtask
  task automatic t_wake;
    wr(ADDR_INT_EN, 8'hFF, 8'h00);
    @(negedge clk);
    sleep_req = 1'b1;
    @(negedge clk);
    sleep_req = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(in_sleep, 1'b1)
    rd_chk(ADDR_CTRL_STATUS, 8'h20);
    // Bus activity with the wake enable clear must leave the device asleep
    rxcan = 1'b0;
    settle();
    `CHK(in_sleep, 1'b1)
    rd_chk(ADDR_INT_FLAGS, 8'h00);
    rxcan = 1'b1;
    settle();
    wr(ADDR_INT_EN, 8'hFF, 8'h40);
    rxcan = 1'b0;
    settle();
    `CHK(in_sleep, 1'b0)
    `CHK(listen_only, 1'b1)
    `CHK(irq_priority_code, CODE_WAKE)
    `CHK(int_n, 1'b0)
    rd_chk(ADDR_CTRL_STATUS, {MODE_ENC_LISTEN, 1'b0, CODE_WAKE, 1'b0});
    rxcan = 1'b1;
    wr(ADDR_INT_FLAGS, 8'h40, 8'h00);
    `CHK(int_n, 1'b1)
    @(negedge clk);
    normal_req = 1'b1;
    @(negedge clk);
    normal_req = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(listen_only, 1'b0)
    // A host-set wake flag while asleep wakes the device as bus activity would
    @(negedge clk);
    sleep_req = 1'b1;
    @(negedge clk);
    sleep_req = 1'b0;
    wr(ADDR_INT_FLAGS, 8'h40, 8'h40);
    `CHK(listen_only, 1'b1)
    `CHK(int_n, 1'b0)
    wr(ADDR_INT_FLAGS, 8'h40, 8'h00);
    `CHK(int_n, 1'b1)
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial
  begin
    #2000000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_wr_addr = 7'h00;
    reg_wr_data = 8'h00;
    reg_wr_mask = 8'h00;
    reg_rd_addr = 7'h00;
    rxcan = 1'b1;
    sleep_req = 1'b0;
    normal_req = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_prio();
    t_mask();
    t_events();
    t_overrun();
    t_levels();
    t_wake();
    test_done();
  end
endmodule // can_controller_interrupt_logic_test

/* File: tb/cirq_eng_model.sv */
// Protocol engine stand-in: bit-clock event pulses and error counts
module cirq_eng_model
  import cirq_pkg::*;
(
  // Bit clock
  input wire logic can_clk,
  // Engine outputs
  output logic [2:0] tx_empty_evt,
  output logic [1:0] rx_full_evt,
  output logic msg_fault_evt,
  output logic [1:0] rx_overrun_evt,
  output logic [CNT_W-1:0] tx_fault_count,
  output logic [CNT_W-1:0] rx_fault_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [EVT_N-1:0] evt_r = '0;
  assign rx_full_evt = evt_r[1:0];
  assign tx_empty_evt = evt_r[4:2];
  assign msg_fault_evt = evt_r[EV_MSG_FAULT];
  assign rx_overrun_evt = evt_r[EV_OVR1:EV_OVR0];
  initial
  begin
    tx_fault_count = '0;
    rx_fault_count = '0;
  end
  // One bit-clock pulse, then a quiet bit so that repeats never merge
  task automatic pulse(input int idx);
    @(negedge can_clk);
    evt_r[idx] = 1'b1;
    @(negedge can_clk);
    evt_r[idx] = 1'b0;
    @(negedge can_clk);
  endtask
  task automatic set_counts(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] r);
    @(negedge can_clk);
    tx_fault_count = t;
    rx_fault_count = r;
  endtask
endmodule // cirq_eng_model
